// file: rtl/flow_averaging_and_flags.sv
// Flow averaging, temperature capture and sticky flags behind an APB slave.
//
// Summary of operation
// [R1] Start command enters continuous mode; a flow sample is taken every 0.5 ms.
// [R2] Within 100 ms of last readout, flow is arithmetic mean of samples since.
// [R3] Past 100 ms, switch to smoothing with factor 0.0125, seeded by the mean.
// [R4] In smoothing mode the latest smoothed value is the flow result.
// [R5] Flag word bit 5 is high while the flow result comes from smoothing.
// [R6] Host should read flow at least once every 100 ms.
// [R7] Temperature result updates about every 12 ms with the newest, unaveraged value.
// [R8] Air and high-flow flags report any detection since the previous readout.
// [R9] Flow beyond the output limit sets flag bit 1 until read out.
// [R10] Air in the channel sets flag bit 0 until read out.
// [R11] High-flow flag may also set at the edges of an air bubble.
// [R12] After power-up the block answers requests within at most 25 ms.
// [R13] After reset the heater is off and idle until the start command.
// [R14] First result appears only after about 12 ms of initialization.
// [R15] Host treats flow within about 50 ms of start as unreliable.
// [R16] Before the first result every read of result data is refused.
// [R17] A readout yields flow, then temperature, then the flag word.
// [R18] Each flow readout clears sum, count and restarts the 100 ms interval.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module flow_averaging_and_flags
    import flow_avg_pkg::*;
#(
    parameter int SAMPLE_CYC_P     = SAMPLE_CYC,
    parameter int AVG_WINDOW_CYC_P = AVG_WINDOW_CYC,
    parameter int TEMP_CYC_P       = TEMP_CYC,
    parameter int INIT_CYC_P       = INIT_CYC,
    parameter int POWER_UP_CYC_P   = POWER_UP_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] flow_sample,
    input  wire logic [15:0] temp_sample,
    input  wire logic        air_detect,
    input  wire logic        high_flow_hint,
    output logic             heater_on,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // State.
    mode_t                 mode_ff;
    logic [CNT_W-1:0]      boot_cnt_ff;
    logic                  boot_done_ff;
    logic [CNT_W-1:0]      init_cnt_ff;
    logic [CNT_W-1:0]      samp_cnt_ff;
    logic [CNT_W-1:0]      temp_cnt_ff;
    logic [CNT_W-1:0]      win_cnt_ff;
    logic                  ready_ff;
    logic                  exp_ff;
    logic signed [23:0]    sum_ff;
    logic [7:0]            count_ff;
    logic [23:0]           mean_fx_ff;
    logic [23:0]           s_fx_ff;
    logic                  div_exp_ff;
    logic [15:0]           temp_ff;
    logic                  air_ff;
    logic                  high_ff;
    logic [15:0]           temp_snap_ff;
    logic [15:0]           flags_snap_ff;
    logic [IRQ_W-1:0]      irq_stat_ff;
    logic [IRQ_W-1:0]      irq_mask_ff;
    logic                  pready_ff;
    logic                  pslverr_ff;
    logic [31:0]           prdata_ff;
    logic                  heater_ff;
    logic                  irq_ff;
    logic                  div_done;
    logic [31:0]           div_q;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode. A request is acted on in its first access cycle, the same
    // edge that loads read data, so read side effects match the data returned.
    wire running   = mode_ff == mode_run;
    wire latch     = psel && penable && !pready_ff;
    wire wr        = latch && pwrite && boot_done_ff;
    wire rd        = latch && !pwrite && boot_done_ff;
    wire hit_ctrl  = paddr == ADDR_CTRL;
    wire hit_stat  = paddr == ADDR_STATUS;
    wire hit_flow  = paddr == ADDR_FLOW;
    wire hit_temp  = paddr == ADDR_TEMP;
    wire hit_flags = paddr == ADDR_FLAGS;
    wire hit_istat = paddr == ADDR_IRQ_STAT;
    wire hit_imask = paddr == ADDR_IRQ_MASK;
    wire hit_data  = hit_flow || hit_temp || hit_flags;
    wire mapped    = hit_ctrl || hit_stat || hit_data || hit_istat || hit_imask;
    // [R16] reject early reads
    wire refuse    = !boot_done_ff || !mapped || (!pwrite && hit_data && !ready_ff);
    wire rd_flow   = rd && hit_flow && ready_ff;
    wire cmd_start = wr && hit_ctrl && pwdata[CTRL_START_BIT];
    wire cmd_stop  = wr && hit_ctrl && pwdata[CTRL_STOP_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Timebase ticks.
    wire sample_tick = running && samp_cnt_ff == CNT_W'(SAMPLE_CYC_P - 1);
    wire temp_tick   = running && temp_cnt_ff == CNT_W'(TEMP_CYC_P - 1);
    wire init_end    = mode_ff == mode_init && init_cnt_ff == CNT_W'(INIT_CYC_P - 1);
    wire win_end     = running && !exp_ff && win_cnt_ff == CNT_W'(AVG_WINDOW_CYC_P - 1);
    wire boot_end    = !boot_done_ff && boot_cnt_ff == CNT_W'(POWER_UP_CYC_P - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Measurement mode.
    // [R13] idle until start
    wire mode_t nxt_mode = cmd_stop ? mode_off :
                           (cmd_start && mode_ff == mode_off) ? mode_init :
                           init_end ? mode_run : mode_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff   <= mode_off;
            heater_ff <= 1'b0;
        end else begin
            mode_ff   <= nxt_mode;
            heater_ff <= nxt_mode != mode_off;
        end
    end

    // [R12] power-up window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_cnt_ff  <= '0;
            boot_done_ff <= 1'b0;
        end else if (!boot_done_ff) begin
            boot_cnt_ff  <= boot_cnt_ff + CNT_W'(1);
            boot_done_ff <= boot_end;
        end
    end

    // [R14] initialization delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_cnt_ff <= '0;
        end else begin
            init_cnt_ff <= mode_ff == mode_init ? init_cnt_ff + CNT_W'(1) : '0;
        end
    end

    // [R1] sample timebase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_cnt_ff <= '0;
            temp_cnt_ff <= '0;
        end else begin
            samp_cnt_ff <= (!running || sample_tick) ? '0 : samp_cnt_ff + CNT_W'(1);
            temp_cnt_ff <= (!running || temp_tick) ? '0 : temp_cnt_ff + CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Averaging. Mean and smoothed value are kept with 8 fraction bits so that
    // the 1/80 step does not stall on small differences.
    wire signed [23:0] x_ext    = {{8{flow_sample[15]}}, flow_sample};
    wire signed [23:0] sum_base = rd_flow ? 24'sh0 : sum_ff;
    wire [7:0]         cnt_base = rd_flow ? 8'h00 : count_ff;
    wire               cnt_full = cnt_base == MAX_COUNT;
    wire signed [23:0] nxt_sum  = cnt_full ? sum_base : sum_base + x_ext;
    wire [7:0]         nxt_cnt  = cnt_full ? cnt_base : cnt_base + 8'h01;
    wire               exp_samp = exp_ff && !rd_flow;
    wire [23:0]        x_fx     = {flow_sample, 8'h00};
    wire [24:0]        delta    = {x_fx[23], x_fx} - {s_fx_ff[23], s_fx_ff};
    wire [31:0]        div_num  = exp_samp ? {{7{delta[24]}}, delta}
                                           : {nxt_sum, 8'h00};
    wire [7:0]         div_den  = exp_samp ? EXP_DIVISOR : nxt_cnt;
    wire [15:0]        flow_abs = flow_sample[15] ? 16'h0 - flow_sample : flow_sample;
    wire               over_lim = flow_abs > HIGH_LIMIT;
    // [R4] result select
    wire [15:0]        flow_res = exp_ff ? s_fx_ff[23:8] : mean_fx_ff[23:8];

    serial_divider i_serial_divider (
        .pclk     (pclk),
        .presetn  (presetn),
        .start    (sample_tick),
        .dividend (div_num),
        .divisor  (div_den),
        .done     (div_done),
        .quotient (div_q)
    );

    // [R2] arithmetic mean
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum_ff     <= 24'sh0;
            count_ff   <= 8'h00;
            mean_fx_ff <= 24'h0;
            div_exp_ff <= 1'b0;
        end else begin
            // [R18] readout restarts
            if (sample_tick && !exp_samp) begin
                sum_ff   <= nxt_sum;
                count_ff <= nxt_cnt;
            end else if (rd_flow || !running) begin
                sum_ff   <= 24'sh0;
                count_ff <= 8'h00;
            end
            if (sample_tick) begin
                div_exp_ff <= exp_samp;
            end
            if (div_done && !div_exp_ff) begin
                mean_fx_ff <= div_q[23:0];
            end
        end
    end

    // [R3] smoothing entry and update
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exp_ff     <= 1'b0;
            s_fx_ff    <= 24'h0;
            win_cnt_ff <= '0;
        end else begin
            win_cnt_ff <= (rd_flow || !running || exp_ff) ? '0 : win_cnt_ff + CNT_W'(1);
            if (rd_flow || !running) begin
                exp_ff <= 1'b0;
            end else if (win_end) begin
                exp_ff  <= 1'b1;
                s_fx_ff <= mean_fx_ff;
            end else if (div_done && div_exp_ff && exp_ff) begin
                s_fx_ff <= s_fx_ff + div_q[23:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Temperature and sticky flags. A detection in the readout cycle lands in
    // the new interval rather than being lost.
    wire set_air  = running && air_detect;
    // [R11] bubble edge hint
    wire set_high = running && (high_flow_hint || (sample_tick && over_lim));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_ff       <= 16'h0;
            air_ff        <= 1'b0;
            high_ff       <= 1'b0;
            temp_snap_ff  <= 16'h0;
            flags_snap_ff <= 16'h0;
            ready_ff      <= 1'b0;
        end else begin
            // [R7] latest temperature
            if (temp_tick || init_end) begin
                temp_ff <= temp_sample;
            end
            // [R10] air sticky
            air_ff  <= set_air || (air_ff && !rd_flow);
            // [R9] high-flow sticky
            high_ff <= set_high || (high_ff && !rd_flow);
            // [R8] readout snapshot
            if (rd_flow) begin
                temp_snap_ff <= temp_ff;
                flags_snap_ff <= 16'h0;
                flags_snap_ff[FLAG_AIR_BIT] <= air_ff;
                flags_snap_ff[FLAG_HIGH_BIT] <= high_ff;
                // [R5] smoothing flag
                flags_snap_ff[FLAG_EXP_BIT] <= exp_ff;
            end
            if (!running) begin
                ready_ff <= 1'b0;
            end else if (div_done) begin
                ready_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts: set wins over a write-one-to-clear in the same cycle.
    wire [IRQ_W-1:0] irq_set = {div_done && !ready_ff, win_end, set_high, set_air, div_done};
    wire [IRQ_W-1:0] irq_clr = (wr && hit_istat) ? pwdata[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] nxt_irq_stat = irq_set | (irq_stat_ff & ~irq_clr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= '0;
            irq_mask_ff <= IRQ_MASK_RST;
            irq_ff      <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            if (wr && hit_imask) begin
                irq_mask_ff <= pwdata[IRQ_W-1:0];
            end
            irq_ff <= |(nxt_irq_stat & irq_mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux and APB answer, one wait state on every access.
    wire [31:0] stat_word = {28'h0, running, exp_ff, ready_ff, boot_done_ff};
    // [R17] readout order
    wire [31:0] rd_word =
        hit_ctrl  ? {31'h0, heater_ff} :
        hit_stat  ? stat_word :
        hit_flow  ? {16'h0, flow_res} :
        hit_temp  ? {16'h0, temp_snap_ff} :
        hit_flags ? {16'h0, flags_snap_ff} :
        hit_istat ? {27'h0, irq_stat_ff} :
        hit_imask ? {27'h0, irq_mask_ff} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else begin
            pready_ff  <= latch;
            pslverr_ff <= latch && refuse;
            if (latch) begin
                prdata_ff <= (rd && !refuse) ? rd_word : 32'h0;
            end
        end
    end

    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;
    assign heater_on = heater_ff;
    assign irq       = irq_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_sample_spacing: assert property (sample_tick |=> (!sample_tick)[*8]) // [R1]
        else $error("flow samples closer than the sample period");
    a_mean_load: assert property (div_done && !div_exp_ff |=> mean_fx_ff == $past(div_q[23:0])) // [R2]
        else $error("mean not loaded from divider");
    a_exp_seed: assert property (win_end && !rd_flow |=> exp_ff && s_fx_ff == $past(mean_fx_ff)) // [R3]
        else $error("smoothing not seeded from the mean");
    a_flow_select: assert property (rd_flow |=> prdata[15:0] == $past(flow_res)) // [R4]
        else $error("flow readout does not carry the selected result");
    a_exp_flag: assert property (rd_flow |=> flags_snap_ff[FLAG_EXP_BIT] == $past(exp_ff)) // [R5]
        else $error("smoothing flag does not match mode");
    a_temp_fresh: assert property (temp_tick |=> temp_ff == $past(temp_sample)) // [R7]
        else $error("temperature not updated on its tick");
    a_high_sticky: assert property (sample_tick && over_lim |=> high_ff [*1] ##1 (high_ff || $past(rd_flow))) // [R9]
        else $error("high-flow flag not held");
    a_air_sticky: assert property (set_air |=> air_ff) // [R10]
        else $error("air flag not set");
    a_boot_refuse: assert property (latch && !boot_done_ff |=> pready && pslverr) // [R12]
        else $error("access during power-up not refused");
    a_idle_heater: assert property (mode_ff == mode_off && !cmd_start |=> !heater_on) // [R13]
        else $error("heater on while idle");
    a_init_noresult: assert property (mode_ff == mode_init |-> !ready_ff) // [R14]
        else $error("result available during initialization");
    a_early_nack: assert property (rd && hit_data && !ready_ff |=> pslverr) // [R16]
        else $error("result read not refused before first result");
    a_readout_clear: assert property (rd_flow && !sample_tick |=> count_ff == 8'h00 && !exp_ff) // [R18]
        else $error("readout did not restart averaging");

    c_exp_entry: cover property (win_end ##[1:20] rd_flow);
    c_flow_read: cover property (ready_ff && rd_flow);
    c_air_flag: cover property (rd_flow && air_ff);
    c_irq_rise: cover property (!irq ##1 irq);

endmodule
`default_nettype wire

// file: rtl/flow_avg_pkg.sv
// Shared constants for the flow averaging and flag block.
package flow_avg_pkg;

    // Clock and timing figures.
    localparam int CLK_PERIOD_NS    = 8;
    localparam int SAMPLE_PERIOD_US = 500;
    localparam int AVG_WINDOW_MS    = 100;
    localparam int TEMP_PERIOD_MS   = 12;
    localparam int INIT_DELAY_MS    = 12;
    localparam int POWER_UP_MS      = 25;
    localparam int SAMPLE_CYC       = (SAMPLE_PERIOD_US * 1000) / CLK_PERIOD_NS;
    localparam int AVG_WINDOW_CYC   = (AVG_WINDOW_MS * 1000000) / CLK_PERIOD_NS;
    localparam int TEMP_CYC         = (TEMP_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
    localparam int INIT_CYC         = (INIT_DELAY_MS * 1000000) / CLK_PERIOD_NS;
    localparam int POWER_UP_CYC     = (POWER_UP_MS * 1000000) / CLK_PERIOD_NS;
    localparam int CNT_W            = 24;

    // Arithmetic: smoothing factor 0.0125 is a divide by 80.
    localparam int         FRAC_W      = 8;
    localparam logic [7:0] EXP_DIVISOR = 8'h50;
    localparam logic [7:0] MAX_COUNT   = 8'hFF;
    localparam logic [15:0] HIGH_LIMIT = 16'h7F00;

    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_FLOW     = 8'h08;
    localparam logic [7:0] ADDR_TEMP     = 8'h0C;
    localparam logic [7:0] ADDR_FLAGS    = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

    // Field positions.
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_STOP_BIT  = 1;
    localparam int STAT_BOOT_BIT  = 0;
    localparam int STAT_READY_BIT = 1;
    localparam int STAT_EXP_BIT   = 2;
    localparam int STAT_RUN_BIT   = 3;
    localparam int FLAG_AIR_BIT   = 0;
    localparam int FLAG_HIGH_BIT  = 1;
    localparam int FLAG_EXP_BIT   = 5;
    localparam int IRQ_SAMPLE_BIT = 0;
    localparam int IRQ_AIR_BIT    = 1;
    localparam int IRQ_HIGH_BIT   = 2;
    localparam int IRQ_EXP_BIT    = 3;
    localparam int IRQ_READY_BIT  = 4;
    localparam int IRQ_W          = 5;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;

    typedef enum logic [2:0] {
        mode_off  = 3'b001,
        mode_init = 3'b010,
        mode_run  = 3'b100
    } mode_t;

endpackage

// file: rtl/serial_divider.sv
// Sequential signed-by-unsigned divider, one quotient bit per clock.
`timescale 1ns/1ps
`default_nettype none
module serial_divider (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic [31:0] dividend,
    input  wire logic [7:0]  divisor,
    output logic             done,
    output logic [31:0]      quotient
);
    logic [31:0] quot_ff;
    logic [7:0]  rem_ff;
    logic [7:0]  div_ff;
    logic [5:0]  cnt_ff;
    logic        neg_ff;
    logic        done_ff;
    logic [31:0] res_ff;

    wire  [31:0] mag      = dividend[31] ? (32'h0 - dividend) : dividend;
    wire  [8:0]  trial    = {rem_ff, quot_ff[31]};
    wire         fits     = trial >= {1'b0, div_ff};
    wire  [8:0]  diff     = trial - {1'b0, div_ff};
    wire  [31:0] nxt_quot = {quot_ff[30:0], fits};
    wire  [7:0]  nxt_rem  = fits ? diff[7:0] : trial[7:0];
    wire         last     = cnt_ff == 6'h01;

    // Quotient truncates toward zero; sign is restored on the last step.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quot_ff <= 32'h0;
            rem_ff  <= 8'h0;
            div_ff  <= 8'h1;
            cnt_ff  <= 6'h0;
            neg_ff  <= 1'b0;
            done_ff <= 1'b0;
            res_ff  <= 32'h0;
        end else begin
            done_ff <= cnt_ff != 6'h0 && last;
            if (start) begin
                quot_ff <= mag;
                rem_ff  <= 8'h0;
                div_ff  <= divisor;
                cnt_ff  <= 6'h20;
                neg_ff  <= dividend[31];
            end else if (cnt_ff != 6'h0) begin
                quot_ff <= nxt_quot;
                rem_ff  <= nxt_rem;
                cnt_ff  <= cnt_ff - 6'h01;
                if (last) begin
                    res_ff <= neg_ff ? (32'h0 - nxt_quot) : nxt_quot;
                end
            end
        end
    end

    assign done     = done_ff;
    assign quotient = res_ff;
endmodule
`default_nettype wire

// file: tb/apb_host.sv
// Host-side APB master model that reads results and issues commands.
`timescale 1ns/1ps
`default_nettype none
module apb_host (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hFF;
        pwdata = 32'hFFFFFFFF;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout may end this wait.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        // Released lines show the inverse so stale values cannot pass.
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// file: tb/flow_averaging_and_flags_tb_top.sv
// Self-checking bench for the flow averaging and flag block.
`timescale 1ns/1ps
`default_nettype none
module flow_averaging_and_flags_tb_top;
    import flow_avg_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, air_detect, high_flow_hint;
    logic        pready, pslverr, heater_on, irq, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] flow_sample, temp_sample;
    int          error_cnt, cmp_count, cyc;
    flow_averaging_and_flags #(.SAMPLE_CYC_P(64), .AVG_WINDOW_CYC_P(640),
        .TEMP_CYC_P(200), .INIT_CYC_P(100), .POWER_UP_CYC_P(20)) i_flow_averaging_and_flags (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flow_sample(flow_sample), .temp_sample(temp_sample),
        .air_detect(air_detect), .high_flow_hint(high_flow_hint),
        .heater_on(heater_on), .irq(irq));
    apb_host i_apb_host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
        i_apb_host.xfer(w, a, d, rd, er);
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] exp, input logic e);
        rw(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, e});
    endtask
    task automatic readout(input logic [31:0] f, input logic [31:0] t, input logic [31:0] g);
        rdx(ADDR_FLOW, f, 1'b0);
        rdx(ADDR_TEMP, t, 1'b0);
        rdx(ADDR_FLAGS, g, 1'b0);
    endtask
    task automatic pulse(input logic a, input logic h);
        @(posedge pclk);
        air_detect <= a;
        high_flow_hint <= h;
        @(posedge pclk);
        air_detect <= 1'b0;
        high_flow_hint <= 1'b0;
    endtask
    task automatic t_boot;
        rdx(ADDR_STATUS, 32'h0, 1'b1);
        chk({31'h0, heater_on}, 32'h0);
        repeat (24) @(posedge pclk);
        rdx(ADDR_STATUS, 32'h1, 1'b0);
        rdx(ADDR_FLOW, 32'h0, 1'b1);
        rdx(8'h1C, 32'h0, 1'b1);
        $display("boot test done");
    endtask
    task automatic t_start;
        int n;
        flow_sample <= 16'h0100;
        rw(1'b1, ADDR_CTRL, 32'h1);
        chk({31'h0, heater_on}, 32'h1);
        rdx(ADDR_FLOW, 32'h0, 1'b1);
        for (n = 0; n < 100 && rd[STAT_READY_BIT] !== 1'b1; n++) rw(1'b0, ADDR_STATUS, 32'h0);
        readout(32'h100, 32'h55, 32'h0);
        $display("start test done");
    endtask
    task automatic t_mean;
        flow_sample <= 16'h0200;
        temp_sample <= 16'h1234;
        @(posedge pclk);
        rw(1'b0, ADDR_FLOW, 32'h0);
        repeat (100) @(posedge pclk);
        pulse(1'b1, 1'b1);
        repeat (220) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        readout(32'h200, 32'h1234, 32'h3);
        repeat (70) @(posedge pclk);
        readout(32'h200, 32'h1234, 32'h0);
        $display("mean test done");
    endtask
    task automatic t_smooth;
        // Readout held back on purpose past the window.
        repeat (800) @(posedge pclk);
        rdx(ADDR_STATUS, 32'hF, 1'b0);
        readout(32'h200, 32'h1234, 32'h20);
        rdx(ADDR_STATUS, 32'hB, 1'b0);
        $display("smoothing test done");
    endtask
    task automatic t_irq;
        rw(1'b1, ADDR_IRQ_STAT, 32'h1F);
        rw(1'b1, ADDR_IRQ_MASK, 32'h2);
        rdx(ADDR_IRQ_MASK, 32'h2, 1'b0);
        pulse(1'b1, 1'b0);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        rw(1'b1, ADDR_IRQ_STAT, 32'h2);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        // Over-limit samples set the high-flow flag.
        flow_sample <= 16'h8000;
        rw(1'b0, ADDR_FLOW, 32'h0);
        repeat (110) @(posedge pclk);
        readout(32'h8000, 32'h1234, 32'h2);
        rw(1'b1, ADDR_CTRL, 32'h2);
        chk({31'h0, heater_on}, 32'h0);
        rdx(ADDR_FLOW, 32'h0, 1'b1);
        $display("interrupt test done");
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // The whole run needs under 2500 cycles; the ceiling leaves margin.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        presetn = 1'b0;
        air_detect = 1'b0;
        high_flow_hint = 1'b0;
        flow_sample = 16'h0000;
        temp_sample = 16'h0055;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_boot();
        t_start();
        t_mean();
        t_smooth();
        t_irq();
        tally_and_finish();
    end
endmodule
`default_nettype wire
